// [bridge_excitation_chopper.sv]
// Bridge excitation chopper: phase sequencer, switch drives and result pairing
// Contract
// - Four drive outputs: true and inverted for forward pair and reverse pair.
// - Forward phase: forward true high, inverted low; reverse pair held off.
// - Reverse phase: reverse true high, inverted low; forward pair held off.
// - Fixed non-overlap gap with all switches off at every phase change.
// - Each result uses one forward and one reverse measurement from consecutive phases.
// - Result equals forward minus reverse measurement, divided by two.
// - Reference swap output ref_swap_o is driven high during the reverse phase.
// - Phase toggles once per measurement, never faster.
// - The first result after each enable waits for two measurements; then one result each.
`timescale 1ns/1ps
module bridge_excitation_chopper #(
	parameter int DATA_W = chopper_pkg::DATA_W_DEFAULT
) (
	input  wire logic                       clock_i,
	input  wire logic                       resetn_i,
	input  wire logic                       ce_i,
	input  wire logic                       chop_enable_i,
	input  wire logic                       meas_valid_i,
	input  wire logic signed [DATA_W-1:0]   meas_data_i,
	output chopper_pkg::drive_pair_type     fwd_pair_drive_o,
	output chopper_pkg::drive_pair_type     rev_pair_drive_o,
	output logic                            ref_swap_o,
	output logic                            result_valid_o,
	output logic signed [DATA_W-1:0]        result_o
);
	import chopper_pkg::*;

	chop_state_type         state_q;
	chop_state_type         state_d;
	logic [GAP_CNT_W-1:0]   gap_cnt_q;
	logic signed [DATA_W-1:0] forward_phase_sample_q;
	logic signed [DATA_W-1:0] reverse_phase_sample_q;
	logic                   have_fwd_q;
	logic                   have_rev_q;
	logic                   pair_valid_q;
	logic                   take_fwd;
	logic                   take_rev;
	logic                   fwd_on;
	logic                   rev_on;

	initial begin
		if (DATA_W < 2) begin
			$error("bridge_excitation_chopper: DATA_W must be at least 2");
		end
		if (GAP_CYCLES > (1 << GAP_CNT_W)) begin
			$error("bridge_excitation_chopper: gap does not fit the gap counter");
		end
		// The gap assertions spell the repetition out as a plain count
		if (GAP_CYCLES != 5) begin
			$error("bridge_excitation_chopper: gap checks are written for five cycles");
		end
	end

	// A measurement counts only in a settled phase; those ending in a gap are dropped
	assign take_fwd = chop_enable_i && meas_valid_i && (state_q == ST_FWD);
	assign take_rev = chop_enable_i && meas_valid_i && (state_q == ST_REV);

	// Leaving the reverse phase always runs the full gap, even on disable, so the
	// forward pair never turns on in the same cycle the reverse pair turns off
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_STATIC: begin
				if (chop_enable_i) begin
					state_d = ST_FWD;
				end
			end
			ST_FWD: begin
				if (!chop_enable_i) begin
					state_d = ST_STATIC;
				end else if (meas_valid_i) begin
					state_d = ST_GAP_TO_REV;
				end
			end
			ST_GAP_TO_REV: begin
				if (!chop_enable_i) begin
					state_d = ST_STATIC;
				end else if (gap_cnt_q == GAP_ZERO) begin
					state_d = ST_REV;
				end
			end
			ST_REV: begin
				if (!chop_enable_i || meas_valid_i) begin
					state_d = ST_GAP_TO_FWD;
				end
			end
			ST_GAP_TO_FWD: begin
				if (gap_cnt_q == GAP_ZERO) begin
					state_d = chop_enable_i ? ST_FWD : ST_STATIC;
				end
			end
		endcase
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			state_q <= ST_STATIC;
		end else if (ce_i) begin
			state_q <= state_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			gap_cnt_q <= GAP_ZERO;
		end else if (ce_i) begin
			if ((state_d == ST_GAP_TO_REV || state_d == ST_GAP_TO_FWD) &&
			    (state_q == ST_FWD || state_q == ST_REV)) begin
				gap_cnt_q <= GAP_LOAD;
			end else if (gap_cnt_q != GAP_ZERO) begin
				gap_cnt_q <= gap_cnt_q - 1'b1;
			end
		end
	end

	// Drives follow the next state so they change on the same edge as the phase
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			fwd_pair_drive_o <= PAIR_ON;
			rev_pair_drive_o <= PAIR_OFF;
		end else if (ce_i) begin
			unique case (state_d)
				ST_STATIC, ST_FWD: begin
					fwd_pair_drive_o <= PAIR_ON;
					rev_pair_drive_o <= PAIR_OFF;
				end
				ST_REV: begin
					fwd_pair_drive_o <= PAIR_OFF;
					rev_pair_drive_o <= PAIR_ON;
				end
				ST_GAP_TO_REV, ST_GAP_TO_FWD: begin
					fwd_pair_drive_o <= PAIR_OFF;
					rev_pair_drive_o <= PAIR_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			ref_swap_o <= 1'b0;
		end else if (ce_i) begin
			ref_swap_o <= (state_d == ST_REV);
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			forward_phase_sample_q <= '0;
			reverse_phase_sample_q <= '0;
		end else if (ce_i) begin
			if (take_fwd) begin
				forward_phase_sample_q <= meas_data_i;
			end
			if (take_rev) begin
				reverse_phase_sample_q <= meas_data_i;
			end
		end
	end

	// Disabling clears history so a stale phase never pairs with a fresh one
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			have_fwd_q <= 1'b0;
			have_rev_q <= 1'b0;
		end else if (ce_i) begin
			if (!chop_enable_i) begin
				have_fwd_q <= 1'b0;
				have_rev_q <= 1'b0;
			end else begin
				if (take_fwd) begin
					have_fwd_q <= 1'b1;
				end
				if (take_rev) begin
					have_rev_q <= 1'b1;
				end
			end
		end
	end

	// First pair needs both phases; afterwards every settled-phase measurement completes a pair
	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			pair_valid_q <= 1'b0;
		end else if (ce_i) begin
			pair_valid_q <= (take_fwd && have_rev_q) || (take_rev && have_fwd_q);
		end
	end

	half_diff_combiner #(
		.DATA_W (DATA_W)
	) u_combiner (
		.clock_i        (clock_i),
		.resetn_i       (resetn_i),
		.ce_i           (ce_i),
		.pair_valid_i   (pair_valid_q),
		.fwd_sample_i   (forward_phase_sample_q),
		.rev_sample_i   (reverse_phase_sample_q),
		.result_valid_o (result_valid_o),
		.result_o       (result_o)
	);

	assign fwd_on = fwd_pair_drive_o.true_drive || !fwd_pair_drive_o.inv_drive;
	assign rev_on = rev_pair_drive_o.true_drive || !rev_pair_drive_o.inv_drive;

	sequence fwd_turns_off;
		$fell(fwd_on);
	endsequence

	sequence gap_then_rev;
		(!rev_on && !fwd_on) [*5] ##1 rev_on;
	endsequence

	sequence rev_turns_off;
		$fell(rev_on);
	endsequence

	sequence gap_then_fwd;
		(!rev_on && !fwd_on) [*5] ##1 fwd_on;
	endsequence

	chk_no_overlap: assert property (@(posedge clock_i) disable iff (!resetn_i)
		!(fwd_on && rev_on))
		else $error("forward and reverse switches on together");

	chk_gap_length: assert property (@(posedge clock_i)
		disable iff (!resetn_i || !ce_i || !chop_enable_i)
		fwd_turns_off |-> gap_then_rev)
		else $error("non-overlap gap is not the set length");

	chk_gap_to_fwd: assert property (@(posedge clock_i) disable iff (!resetn_i || !ce_i)
		rev_turns_off |-> gap_then_fwd)
		else $error("reverse to forward gap is not the set length");

	chk_fwd_levels: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state_q == ST_FWD) |-> (fwd_pair_drive_o == PAIR_ON && rev_pair_drive_o == PAIR_OFF))
		else $error("forward phase drive levels wrong");

	chk_rev_levels: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(state_q == ST_REV) |-> (rev_pair_drive_o == PAIR_ON && fwd_pair_drive_o == PAIR_OFF))
		else $error("reverse phase drive levels wrong");

	chk_ref_swap: assert property (@(posedge clock_i) disable iff (!resetn_i)
		ref_swap_o == (rev_pair_drive_o == PAIR_ON))
		else $error("reference swap does not track reverse phase");

	chk_static_off: assert property (@(posedge clock_i) disable iff (!resetn_i || !ce_i)
		(!chop_enable_i && !rev_on && gap_cnt_q == GAP_ZERO)
		|=> (fwd_pair_drive_o == PAIR_ON && rev_pair_drive_o == PAIR_OFF))
		else $error("disabled chopper not at static levels");

	chk_one_toggle: assert property (@(posedge clock_i) disable iff (!resetn_i || !ce_i)
		(state_q == ST_FWD && !meas_valid_i && chop_enable_i) |=> (state_q == ST_FWD))
		else $error("phase changed without a measurement");

	chk_result_cause: assert property (@(posedge clock_i) disable iff (!resetn_i || !ce_i)
		result_valid_o |-> $past(take_fwd || take_rev, 2))
		else $error("result without a completing measurement");

	chk_first_wait: assert property (@(posedge clock_i) disable iff (!resetn_i || !ce_i)
		(take_fwd && !have_rev_q) |=> !pair_valid_q)
		else $error("result formed from a single phase");

endmodule : bridge_excitation_chopper

// [bridge_switch_model.sv]
// Behavioural model of the external switches and the resistive bridge they excite
`timescale 1ns/1ps
module bridge_switch_model #(
	parameter int W = 24
) (
	input  wire logic                   clock_i,
	input  chopper_pkg::drive_pair_type fwd_i,
	input  chopper_pkg::drive_pair_type rev_i,
	input  wire logic signed [W-1:0]    sig_i,
	input  wire logic signed [W-1:0]    offset_i,
	output logic signed [W-1:0]         level_o,
	output logic                        short_o
);
	import chopper_pkg::*;
	logic [W-1:0] float_q = '0;
	logic         fwd_any;
	logic         rev_any;
	logic         fwd_full;
	logic         rev_full;

	// Each drive output works one switch: true high closes the low side, inverted low the high side
	assign fwd_any  = fwd_i.true_drive | ~fwd_i.inv_drive;
	assign rev_any  = rev_i.true_drive | ~rev_i.inv_drive;
	assign fwd_full = fwd_i.true_drive & ~fwd_i.inv_drive;
	assign rev_full = rev_i.true_drive & ~rev_i.inv_drive;
	// Opposing switches closed together would short the excitation supply
	assign short_o  = fwd_any & rev_any;

	// An unexcited bridge floats, so show a pattern that never matches a held value
	always @(posedge clock_i) begin
		float_q <= ~float_q;
	end

	always_comb begin
		if (fwd_full && !rev_any) begin
			level_o = sig_i - offset_i;
		end else if (rev_full && !fwd_any) begin
			level_o = -sig_i - offset_i;
		end else begin
			level_o = float_q;
		end
	end
endmodule : bridge_switch_model

// [chopper_pkg.sv]
// Shared constants and types for the bridge excitation chopper
package chopper_pkg;

	// One complementary drive pair: true side and inverted side
	typedef struct packed {
		logic true_drive;
		logic inv_drive;
	} drive_pair_type;

	localparam drive_pair_type PAIR_ON  = '{true_drive: 1'b1, inv_drive: 1'b0};
	localparam drive_pair_type PAIR_OFF = '{true_drive: 1'b0, inv_drive: 1'b1};

	// Clock and non-overlap gap timing
	localparam int CLOCK_PERIOD_NS = 100;
	localparam int GAP_TIME_NS     = 500;
	// Least time: round up to whole cycles, at least one
	localparam int GAP_CYCLES_RAW  = (GAP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int GAP_CYCLES      = (GAP_CYCLES_RAW < 1) ? 1 : GAP_CYCLES_RAW;
	localparam int GAP_CNT_W       = 4;
	localparam logic [GAP_CNT_W-1:0] GAP_LOAD = GAP_CNT_W'(GAP_CYCLES - 1);
	localparam logic [GAP_CNT_W-1:0] GAP_ZERO = 4'h0;

	localparam int DATA_W_DEFAULT = 24;

	typedef enum logic [2:0] {
		ST_STATIC,
		ST_FWD,
		ST_GAP_TO_REV,
		ST_REV,
		ST_GAP_TO_FWD
	} chop_state_type;

endpackage : chopper_pkg

// [half_diff_combiner.sv]
// Combines one forward and one reverse measurement as half their difference
`timescale 1ns/1ps
module half_diff_combiner #(
	parameter int DATA_W = chopper_pkg::DATA_W_DEFAULT
) (
	input  wire logic                     clock_i,
	input  wire logic                     resetn_i,
	input  wire logic                     ce_i,
	input  wire logic                     pair_valid_i,
	input  wire logic signed [DATA_W-1:0] fwd_sample_i,
	input  wire logic signed [DATA_W-1:0] rev_sample_i,
	output logic                          result_valid_o,
	output logic signed [DATA_W-1:0]      result_o
);
	import chopper_pkg::*;

	logic signed [DATA_W:0] diff;

	initial begin
		if (DATA_W < 2) begin
			$error("half_diff_combiner: DATA_W must be at least 2");
		end
	end

	// One extra bit keeps the difference exact before halving
	assign diff = (DATA_W+1)'(fwd_sample_i) - (DATA_W+1)'(rev_sample_i);

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			result_valid_o <= 1'b0;
		end else if (ce_i) begin
			result_valid_o <= pair_valid_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (!resetn_i) begin
			result_o <= '0;
		end else if (ce_i && pair_valid_i) begin
			result_o <= diff[DATA_W:1];
		end
	end

	chk_half_diff_value: assert property (@(posedge clock_i) disable iff (!resetn_i)
		(ce_i && pair_valid_i) |=> (result_o == $past(diff[DATA_W:1])))
		else $error("combined result is not half of forward minus reverse");

endmodule : half_diff_combiner

// [test_bridge_excitation_chopper.sv]
// Self-checking testbench for the bridge excitation chopper
`timescale 1ns/1ps
`define CHECK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
	$display("[FAIL] %0t ns: got %0h expected %0h", $time, got, exp); end end
module test_bridge_excitation_chopper;
	import chopper_pkg::*;
	localparam int W = 24;
	logic                clock_i       = 1'b0;
	logic                resetn_i      = 1'b0;
	logic                ce_i          = 1'b1;
	logic                chop_enable_i = 1'b0;
	logic                meas_valid_i  = 1'b0;
	logic signed [W-1:0] meas_data_i   = '0;
	drive_pair_type      fwd_pair_drive_o;
	drive_pair_type      rev_pair_drive_o;
	logic                ref_swap_o;
	logic                result_valid_o;
	logic signed [W-1:0] result_o;
	logic signed [W-1:0] sig           = -500;
	logic signed [W-1:0] offset        = 37;
	logic signed [W-1:0] level;
	logic signed [W-1:0] last_fwd;
	logic signed [W-1:0] last_rev;
	logic                short_w;
	int                  n_errors      = 0;
	int                  check_count   = 0;
	int                  n_results     = 0;
	int                  exp_results   = 0;

	always #50 clock_i = ~clock_i;

	bridge_excitation_chopper #(.DATA_W(W)) bridge_excitation_chopper_i (
		.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .chop_enable_i(chop_enable_i),
		.meas_valid_i(meas_valid_i), .meas_data_i(meas_data_i),
		.fwd_pair_drive_o(fwd_pair_drive_o), .rev_pair_drive_o(rev_pair_drive_o),
		.ref_swap_o(ref_swap_o), .result_valid_o(result_valid_o), .result_o(result_o));

	bridge_switch_model #(.W(W)) bridge_switch_model_i (
		.clock_i(clock_i), .fwd_i(fwd_pair_drive_o), .rev_i(rev_pair_drive_o),
		.sig_i(sig), .offset_i(offset), .level_o(level), .short_o(short_w));

	always @(posedge clock_i) begin
		if (result_valid_o === 1'b1) n_results++;
	end

	always @(negedge clock_i) begin
		if (resetn_i) `CHECK(short_w, 1'b0)
	end

	task automatic results;
		$display("Errors: %0d, checks: %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : results

	task automatic check_drives(input drive_pair_type f, input drive_pair_type r, input logic s);
		`CHECK(fwd_pair_drive_o, f)
		`CHECK(rev_pair_drive_o, r)
		`CHECK(ref_swap_o, s)
	endtask : check_drives

	// Send the bridge level plus delta as a one-cycle measurement pulse
	task automatic measure(input logic signed [W-1:0] delta, output logic signed [W-1:0] sent);
		@(negedge clock_i);
		sent = level + delta;
		meas_valid_i = 1'b1;
		meas_data_i = sent;
		@(negedge clock_i);
		meas_valid_i = 1'b0;
	endtask : measure

	// One phase: measure, walk the gap (optionally poking a stray pulse), check next phase
	task automatic step(input logic signed [W-1:0] delta, input logic want, input logic poke,
			input drive_pair_type f, input drive_pair_type r, input logic s);
		logic signed [W-1:0] sent;
		logic                rev_phase;
		rev_phase = (rev_pair_drive_o === PAIR_ON);
		measure(delta, sent);
		if (rev_phase) last_rev = sent;
		else last_fwd = sent;
		check_drives(PAIR_OFF, PAIR_OFF, 1'b0);
		for (int i = 1; i < GAP_CYCLES; i++) begin
			@(negedge clock_i);
			meas_valid_i = poke && (i == 1);
			// The combined result stands for the one cycle after the pair is formed
			if (i == 1) begin
				`CHECK(result_valid_o, want)
				if (want) `CHECK(result_o, (last_fwd - last_rev) >>> 1)
			end
			check_drives(PAIR_OFF, PAIR_OFF, 1'b0);
		end
		@(negedge clock_i);
		check_drives(f, r, s);
		if (want) exp_results++;
		`CHECK(n_results, exp_results)
	endtask : step

	// Frozen clock enable or disabled chopping: drives hold, measurements give nothing
	task automatic idle_check(input logic en, input logic ce);
		logic signed [W-1:0] sent;
		@(negedge clock_i);
		chop_enable_i = en;
		ce_i = ce;
		measure(0, sent);
		repeat (4) @(negedge clock_i);
		check_drives(PAIR_ON, PAIR_OFF, 1'b0);
		`CHECK(n_results, exp_results)
		ce_i = 1'b1;
	endtask : idle_check

	initial begin
		#(100 * 2000);
		n_errors++;
		$display("[FAIL] %0t ns: watchdog expired", $time);
		results();
	end

	initial begin
		repeat (8) @(negedge clock_i);
		check_drives(PAIR_ON, PAIR_OFF, 1'b0);
		`CHECK(result_o, '0)
		`CHECK(result_valid_o, 1'b0)
		resetn_i = 1'b1;
		idle_check(1'b0, 1'b1);
		chop_enable_i = 1'b1;
		@(negedge clock_i);
		step(0, 1'b0, 1'b0, PAIR_OFF, PAIR_ON, 1'b1);
		step(0, 1'b1, 1'b1, PAIR_ON, PAIR_OFF, 1'b0);
		step(3, 1'b1, 1'b0, PAIR_OFF, PAIR_ON, 1'b1);
		step(0, 1'b1, 1'b0, PAIR_ON, PAIR_OFF, 1'b0);
		idle_check(1'b1, 1'b0);
		idle_check(1'b0, 1'b1);
		chop_enable_i = 1'b1;
		@(negedge clock_i);
		// History is discarded on disable, so the first result waits again
		step(5, 1'b0, 1'b0, PAIR_OFF, PAIR_ON, 1'b1);
		// Disabling in the reverse phase still runs the full gap before static levels
		chop_enable_i = 1'b0;
		@(negedge clock_i);
		check_drives(PAIR_OFF, PAIR_OFF, 1'b0);
		repeat (GAP_CYCLES) @(negedge clock_i);
		check_drives(PAIR_ON, PAIR_OFF, 1'b0);
		results();
	end
endmodule : test_bridge_excitation_chopper
